// file: bsl_pkg.sv
// package for the branch, skip and load execution block
// assumes one core clock; register file and data space sit outside the block
package bsl_pkg;

    // status flag bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // reset values
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [7:0]  FLAGS_RESET = 8'h00;
    localparam logic [7:0]  DATA_RESET  = 8'h00;

    // cycle counts and pc step
    localparam logic [2:0] CYC_ONE        = 3'h1;
    localparam logic [2:0] CYC_TWO        = 3'h2;
    localparam logic [2:0] CYC_IO_EXTRA   = 3'h1;
    localparam logic [15:0] PC_STEP       = 16'h0001;

    // operation codes handed in by the fetch/decode front end
    typedef enum logic [4:0] {
        OP_NOP,
        OP_COMPARE_REGS,
        OP_COMPARE_REGS_CARRY,
        OP_COMPARE_IMMEDIATE,
        OP_COMPARE_SKIP_EQUAL,
        OP_SKIP_REG_BIT_CLEAR,
        OP_SKIP_REG_BIT_SET,
        OP_SKIP_IO_BIT_CLEAR,
        OP_SKIP_IO_BIT_SET,
        OP_BRANCH_FLAG_SET,
        OP_BRANCH_FLAG_CLEAR,
        OP_BRANCH_SIGNED_GE,
        OP_BRANCH_SIGNED_LT,
        OP_LOAD_DIRECT,
        OP_LOAD_PTR,
        OP_LOAD_PTR_INC,
        OP_LOAD_PTR_DEC
    } op_t;

    // one decoded instruction
    typedef struct packed {
        op_t         op;
        logic [7:0]  rd_val;     // destination / tested register value
        logic [7:0]  rr_val;     // source register value or immediate
        logic [2:0]  bit_sel;    // bit or status flag selector
        logic [6:0]  offset;     // signed relative offset
        logic [15:0] addr;       // direct address or pointer pair value
        logic        next_long;  // following instruction is two words
    } instr_t;

    // result toward register file, pointer pair and pc
    typedef struct packed {
        logic        rd_we;
        logic [7:0]  rd_data;
        logic        ptr_we;
        logic [15:0] ptr_data;
        logic [15:0] pc;
    } result_t;

endpackage

// file: branch_skip_load_exec.sv
// execution unit for compares, skips, relative branches and data loads
// assumes decoded operands arrive with a one-cycle issue strobe and that
// data and i/o reads answer while the read strobe stands
//
// Function
// - equal registers skip next instruction, 1/2/3 cycles
// - compare subtracts, sets six flags, one cycle
// - skip next when register bit is zero
// - skip next when register bit is one
// - skip next when i/o bit is zero
// - skip next when i/o bit is one
// - branch to pc+k+1 when flag set
// - branch when flag clear; not-equal/plus forms included
// - carry branches via flag set/clear forms
// - signed ge branch when n xor v zero
// - signed lt branch when n xor v one
// - half-carry branches, 1 or 2 cycles
// - transfer bit branches, flags untouched
// - overflow flag branches, 1 or 2 cycles
// - interrupt-enable flag branches, 1 or 2 cycles
// - direct load from data space, two cycles
// - post-increment load reads then bumps pointer
// - pre-decrement load drops pointer then reads
`timescale 1ns/100ps

module branch_skip_load_exec (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    // instruction issue
    input  wire logic                 issue_in,
    input  wire bsl_pkg::instr_t      instr_in,
    output logic                      busy_out,
    // status flags from the flag register
    input  wire logic [7:0]           status_flags_reg_in,
    // data space and i/o read port
    output logic                      mem_rd_out,
    output logic                      mem_io_out,
    output logic [15:0]               mem_addr_out,
    input  wire logic [7:0]           mem_data_in,
    // results
    output logic                      done_out,
    output bsl_pkg::result_t          result_out,
    output logic                      flags_we_out,
    output logic [7:0]                flags_out,
    output logic [2:0]                cycles_out
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_MEM,
        ST_TEST_IO
    } state_t;

    state_t             state_r;
    bsl_pkg::instr_t    ins_r;
    logic [15:0]        pc_r;
    logic [2:0]         wait_r;
    logic [2:0]         cyc_r;
    logic [15:0]        target_r;
    logic               load_pending_r;

    // cycles of a skip: none, one or two words passed over
    function automatic logic [2:0] skip_cycles(input logic taken, input logic long_next);
        if (!taken) begin
            skip_cycles = bsl_pkg::CYC_ONE;
        end else if (long_next) begin
            skip_cycles = 3'h3;
        end else begin
            skip_cycles = bsl_pkg::CYC_TWO;
        end
    endfunction

    // words to skip over
    function automatic logic [15:0] skip_words(input logic long_next);
        skip_words = long_next ? 16'h0002 : 16'h0001;
    endfunction

    // compare flags: subtraction without a stored result
    function automatic logic [7:0] cmp_flags(input logic [7:0] a, input logic [7:0] b,
                                             input logic use_c, input logic [7:0] fin);
        logic [8:0] diff;
        logic [7:0] r;
        logic       cin;
        logic       v;
        logic       n;
        r    = 8'h00;
        cin  = use_c & fin[bsl_pkg::FLAG_C];
        diff = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        r    = fin;
        n    = diff[7];
        v    = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
        r[bsl_pkg::FLAG_C] = diff[8];
        // carry form keeps zero only if it was already set
        r[bsl_pkg::FLAG_Z] = (diff[7:0] == 8'h00) & (use_c ? fin[bsl_pkg::FLAG_Z] : 1'b1);
        r[bsl_pkg::FLAG_N] = n;
        r[bsl_pkg::FLAG_V] = v;
        r[bsl_pkg::FLAG_S] = n ^ v;
        r[bsl_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
        cmp_flags = r;
    endfunction

    // relative target, offset sign-extended
    function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [6:0] k);
        rel_target = pc + {{9{k[6]}}, k} + bsl_pkg::PC_STEP;
    endfunction

    logic        flag_bit;
    logic        branch_take;
    logic        reg_bit;
    logic [7:0]  flags_cmp;
    logic        io_hit;
    logic [2:0]  io_cyc;

    always_comb begin
        flag_bit    = status_flags_reg_in[instr_in.bit_sel];
        reg_bit     = instr_in.rd_val[instr_in.bit_sel];
        branch_take = 1'b0;
        case (instr_in.op)
            bsl_pkg::OP_BRANCH_FLAG_SET:   branch_take = flag_bit;
            bsl_pkg::OP_BRANCH_FLAG_CLEAR: branch_take = ~flag_bit;
            bsl_pkg::OP_BRANCH_SIGNED_GE:  branch_take = (status_flags_reg_in[bsl_pkg::FLAG_N]
                                                          ^ status_flags_reg_in[bsl_pkg::FLAG_V]) == 1'b0;
            bsl_pkg::OP_BRANCH_SIGNED_LT:  branch_take = (status_flags_reg_in[bsl_pkg::FLAG_N]
                                                          ^ status_flags_reg_in[bsl_pkg::FLAG_V]) == 1'b1;
            default:                       branch_take = 1'b0;
        endcase
        flags_cmp = cmp_flags(instr_in.rd_val, instr_in.rr_val,
                              instr_in.op == bsl_pkg::OP_COMPARE_REGS_CARRY, status_flags_reg_in);
        io_hit    = mem_data_in[ins_r.bit_sel] == (ins_r.op == bsl_pkg::OP_SKIP_IO_BIT_SET);
        io_cyc    = skip_cycles(io_hit, ins_r.next_long) + bsl_pkg::CYC_IO_EXTRA;
    end

    // control state; one instruction in flight, multi-cycle ones hold busy
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r        <= ST_IDLE;
            ins_r          <= '0;
            wait_r         <= 3'h0;
            load_pending_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (issue_in) begin
                        ins_r <= instr_in;
                        if (instr_in.op == bsl_pkg::OP_SKIP_IO_BIT_CLEAR ||
                            instr_in.op == bsl_pkg::OP_SKIP_IO_BIT_SET) begin
                            state_r <= ST_TEST_IO;
                        end else if (instr_in.op == bsl_pkg::OP_LOAD_DIRECT ||
                                     instr_in.op == bsl_pkg::OP_LOAD_PTR_DEC) begin
                            state_r        <= ST_MEM;
                            load_pending_r <= 1'b1;
                        end else if (instr_in.op == bsl_pkg::OP_LOAD_PTR ||
                                     instr_in.op == bsl_pkg::OP_LOAD_PTR_INC) begin
                            state_r        <= ST_MEM;
                            load_pending_r <= 1'b1;
                        end else if (skip_cycles(1'b1, 1'b0) != 3'h0 && wait_r == 3'h0 &&
                                     (cyc_nxt_of(instr_in) > bsl_pkg::CYC_ONE)) begin
                            state_r <= ST_WAIT;
                            wait_r  <= cyc_nxt_of(instr_in) - bsl_pkg::CYC_ONE;
                        end
                    end
                end
                ST_WAIT: begin
                    wait_r <= wait_r - 3'h1;
                    if (wait_r == 3'h1) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_MEM: begin
                    load_pending_r <= 1'b0;
                    state_r        <= ST_IDLE;
                end
                ST_TEST_IO: begin
                    if (io_cyc > bsl_pkg::CYC_TWO) begin
                        state_r <= ST_WAIT;
                        wait_r  <= io_cyc - bsl_pkg::CYC_TWO;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // total cycles of a register-only instruction
    function automatic logic [2:0] cyc_nxt_of(input bsl_pkg::instr_t i);
        logic bt;
        logic fb;
        bt = 1'b0;
        fb = status_flags_reg_in[i.bit_sel];
        case (i.op)
            bsl_pkg::OP_COMPARE_SKIP_EQUAL: cyc_nxt_of = skip_cycles(i.rd_val == i.rr_val, i.next_long);
            bsl_pkg::OP_SKIP_REG_BIT_CLEAR: cyc_nxt_of = skip_cycles(~i.rd_val[i.bit_sel], i.next_long);
            bsl_pkg::OP_SKIP_REG_BIT_SET:   cyc_nxt_of = skip_cycles(i.rd_val[i.bit_sel], i.next_long);
            bsl_pkg::OP_BRANCH_FLAG_SET,
            bsl_pkg::OP_BRANCH_FLAG_CLEAR,
            bsl_pkg::OP_BRANCH_SIGNED_GE,
            bsl_pkg::OP_BRANCH_SIGNED_LT: begin
                bt = branch_take;
                cyc_nxt_of = bt ? bsl_pkg::CYC_TWO : bsl_pkg::CYC_ONE;
            end
            default: cyc_nxt_of = bsl_pkg::CYC_ONE;
        endcase
        if (fb) begin
            bt = ~bt;
        end
    endfunction

    // program counter; skips and taken branches jump, direct load steps by two, all else steps by one
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pc_r     <= bsl_pkg::PC_RESET;
            cyc_r    <= 3'h0;
            target_r <= bsl_pkg::PC_RESET;
        end else if (state_r == ST_IDLE && issue_in) begin
            cyc_r <= cyc_nxt_of(instr_in);
            case (instr_in.op)
                bsl_pkg::OP_COMPARE_SKIP_EQUAL:
                    pc_r <= pc_r + bsl_pkg::PC_STEP
                            + ((instr_in.rd_val == instr_in.rr_val) ? skip_words(instr_in.next_long) : 16'h0000);
                bsl_pkg::OP_SKIP_REG_BIT_CLEAR:
                    pc_r <= pc_r + bsl_pkg::PC_STEP + (~reg_bit ? skip_words(instr_in.next_long) : 16'h0000);
                bsl_pkg::OP_SKIP_REG_BIT_SET:
                    pc_r <= pc_r + bsl_pkg::PC_STEP + (reg_bit ? skip_words(instr_in.next_long) : 16'h0000);
                bsl_pkg::OP_BRANCH_FLAG_SET,
                bsl_pkg::OP_BRANCH_FLAG_CLEAR,
                bsl_pkg::OP_BRANCH_SIGNED_GE,
                bsl_pkg::OP_BRANCH_SIGNED_LT:
                    pc_r <= branch_take ? rel_target(pc_r, instr_in.offset) : pc_r + bsl_pkg::PC_STEP;
                bsl_pkg::OP_LOAD_DIRECT:
                    pc_r <= pc_r + 16'h0002; // address word follows the opcode
                bsl_pkg::OP_SKIP_IO_BIT_CLEAR,
                bsl_pkg::OP_SKIP_IO_BIT_SET:
                    target_r <= pc_r + bsl_pkg::PC_STEP + skip_words(instr_in.next_long);
                default:
                    pc_r <= pc_r + bsl_pkg::PC_STEP;
            endcase
        end else if (state_r == ST_TEST_IO) begin
            // i/o bit only known now, so the extra cycle is spent here
            if (io_hit) begin
                pc_r  <= target_r;
                cyc_r <= io_cyc;
            end else begin
                pc_r  <= pc_r + bsl_pkg::PC_STEP;
                cyc_r <= bsl_pkg::CYC_TWO;
            end
        end
    end

    // memory read port; pre-decrement presents the lowered pointer
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mem_rd_out   <= 1'b0;
            mem_io_out   <= 1'b0;
            mem_addr_out <= 16'h0000;
        end else if (state_r == ST_IDLE && issue_in) begin
            mem_rd_out <= instr_in.op == bsl_pkg::OP_LOAD_DIRECT  || instr_in.op == bsl_pkg::OP_LOAD_PTR ||
                          instr_in.op == bsl_pkg::OP_LOAD_PTR_INC || instr_in.op == bsl_pkg::OP_LOAD_PTR_DEC ||
                          instr_in.op == bsl_pkg::OP_SKIP_IO_BIT_CLEAR || instr_in.op == bsl_pkg::OP_SKIP_IO_BIT_SET;
            mem_io_out <= instr_in.op == bsl_pkg::OP_SKIP_IO_BIT_CLEAR || instr_in.op == bsl_pkg::OP_SKIP_IO_BIT_SET;
            mem_addr_out <= (instr_in.op == bsl_pkg::OP_LOAD_PTR_DEC) ? instr_in.addr - bsl_pkg::PC_STEP
                                                                      : instr_in.addr;
        end else begin
            mem_rd_out <= 1'b0;
            mem_io_out <= 1'b0;
        end
    end

    // results and completion
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            done_out     <= 1'b0;
            result_out   <= '0;
            flags_we_out <= 1'b0;
            flags_out    <= bsl_pkg::FLAGS_RESET;
            cycles_out   <= 3'h0;
        end else begin
            done_out            <= 1'b0;
            flags_we_out        <= 1'b0;
            result_out.rd_we    <= 1'b0;
            result_out.ptr_we   <= 1'b0;
            result_out.pc       <= pc_r;
            if (state_r == ST_IDLE && issue_in) begin
                if (instr_in.op == bsl_pkg::OP_COMPARE_REGS || instr_in.op == bsl_pkg::OP_COMPARE_REGS_CARRY ||
                    instr_in.op == bsl_pkg::OP_COMPARE_IMMEDIATE) begin
                    flags_we_out <= 1'b1;
                    flags_out    <= flags_cmp;
                end
                if (cyc_nxt_of(instr_in) == bsl_pkg::CYC_ONE &&
                    instr_in.op != bsl_pkg::OP_SKIP_IO_BIT_CLEAR && instr_in.op != bsl_pkg::OP_SKIP_IO_BIT_SET &&
                    instr_in.op != bsl_pkg::OP_LOAD_DIRECT && instr_in.op != bsl_pkg::OP_LOAD_PTR_DEC &&
                    instr_in.op != bsl_pkg::OP_LOAD_PTR && instr_in.op != bsl_pkg::OP_LOAD_PTR_INC) begin
                    done_out   <= 1'b1;
                    cycles_out <= bsl_pkg::CYC_ONE;
                end
            end else if (state_r == ST_MEM && load_pending_r) begin
                result_out.rd_we   <= 1'b1;
                result_out.rd_data <= mem_data_in;
                done_out           <= 1'b1;
                if (ins_r.op == bsl_pkg::OP_LOAD_PTR_INC) begin
                    result_out.ptr_we   <= 1'b1;
                    result_out.ptr_data <= ins_r.addr + bsl_pkg::PC_STEP;
                    cycles_out          <= bsl_pkg::CYC_ONE;
                end else if (ins_r.op == bsl_pkg::OP_LOAD_PTR_DEC) begin
                    result_out.ptr_we   <= 1'b1;
                    result_out.ptr_data <= ins_r.addr - bsl_pkg::PC_STEP;
                    cycles_out          <= bsl_pkg::CYC_TWO;
                end else if (ins_r.op == bsl_pkg::OP_LOAD_DIRECT) begin
                    cycles_out <= bsl_pkg::CYC_TWO;
                end else begin
                    cycles_out <= bsl_pkg::CYC_ONE;
                end
            end else if (state_r == ST_WAIT && wait_r == 3'h1) begin
                done_out   <= 1'b1;
                cycles_out <= cyc_r;
            end else if (state_r == ST_TEST_IO && !io_hit) begin
                done_out   <= 1'b1;
                cycles_out <= bsl_pkg::CYC_TWO;
            end
        end
    end

    // busy while a multi-cycle instruction holds the unit; flags untouched
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= (state_r == ST_IDLE) ? (issue_in && (cyc_nxt_of(instr_in) > bsl_pkg::CYC_ONE ||
                        instr_in.op == bsl_pkg::OP_SKIP_IO_BIT_CLEAR || instr_in.op == bsl_pkg::OP_SKIP_IO_BIT_SET ||
                        instr_in.op == bsl_pkg::OP_LOAD_DIRECT || instr_in.op == bsl_pkg::OP_LOAD_PTR_DEC ||
                        instr_in.op == bsl_pkg::OP_LOAD_PTR || instr_in.op == bsl_pkg::OP_LOAD_PTR_INC))
                        : !((state_r == ST_WAIT && wait_r == 3'h1) || state_r == ST_MEM ||
                            (state_r == ST_TEST_IO && !io_hit));
        end
    end

endmodule

// file: branch_skip_load_exec_checker.sv
// assertions for the branch, skip and load execution unit
// sees only the unit's ports; bound to every instance at the foot of the file
`timescale 1ns/100ps
module branch_skip_load_exec_checker (
    // watched ports
    input wire logic             clk_in,
    input wire logic             rst_n_in,
    input wire logic             issue_in,
    input wire bsl_pkg::instr_t  instr_in,
    input wire logic             busy_out,
    input wire logic [7:0]       status_flags_reg_in,
    input wire logic             mem_rd_out,
    input wire logic             mem_io_out,
    input wire logic [15:0]      mem_addr_out,
    input wire logic             done_out,
    input wire bsl_pkg::result_t result_out,
    input wire logic             flags_we_out,
    input wire logic [2:0]       cycles_out
);
    logic         take;
    bsl_pkg::op_t op;
    logic         nxv;
    assign take = issue_in && !busy_out;
    assign op = instr_in.op;
    assign nxv = status_flags_reg_in[bsl_pkg::FLAG_N] ^ status_flags_reg_in[bsl_pkg::FLAG_V];
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence read_s(logic io);
        ##1 mem_rd_out && mem_io_out == io;
    endsequence
    sequence done_s(int n);
        ##[1:4] done_out && cycles_out == n;
    endsequence
    cmp_flags_a: assert property (take && op inside {[bsl_pkg::OP_COMPARE_REGS:bsl_pkg::OP_COMPARE_IMMEDIATE]}
        |-> ##1 flags_we_out && done_out && cycles_out == 3'h1) else $error("compare result late");
    compare_skip_equal_skip_a: assert property (take && op == bsl_pkg::OP_COMPARE_SKIP_EQUAL && instr_in.next_long
        && instr_in.rd_val == instr_in.rr_val |-> done_s(3)) else $error("equal skip count");
    reg_clr_skip_a: assert property (take && op == bsl_pkg::OP_SKIP_REG_BIT_CLEAR && !instr_in.next_long
        && !instr_in.rd_val[instr_in.bit_sel] |-> done_s(2)) else $error("bit clear skip count");
    reg_set_skip_a: assert property (take && op == bsl_pkg::OP_SKIP_REG_BIT_SET && instr_in.next_long
        && instr_in.rd_val[instr_in.bit_sel] |-> done_s(3)) else $error("bit set skip count");
    io_skip_read_a: assert property (take && op inside {bsl_pkg::OP_SKIP_IO_BIT_CLEAR,
        bsl_pkg::OP_SKIP_IO_BIT_SET} |-> read_s(1'b1)) else $error("io skip read missing");
    flag_set_br_a: assert property (take && op == bsl_pkg::OP_BRANCH_FLAG_SET
        && status_flags_reg_in[instr_in.bit_sel] |-> done_s(2)) else $error("taken branch count");
    flag_clr_br_a: assert property (take && op == bsl_pkg::OP_BRANCH_FLAG_CLEAR
        && status_flags_reg_in[instr_in.bit_sel] |-> ##1 done_out && cycles_out == 3'h1 && !flags_we_out)
        else $error("untaken branch wrong");
    signed_ge_a: assert property (take && op == bsl_pkg::OP_BRANCH_SIGNED_GE |-> done_s(nxv ? 1 : 2))
        else $error("signed ge count");
    signed_lt_a: assert property (take && op == bsl_pkg::OP_BRANCH_SIGNED_LT |-> done_s(nxv ? 2 : 1))
        else $error("signed lt count");
    load_direct_a: assert property (take && op == bsl_pkg::OP_LOAD_DIRECT |-> read_s(1'b0)
        ##0 mem_addr_out == $past(instr_in.addr) ##1 done_out && result_out.rd_we) else $error("direct load");
    post_inc_a: assert property (take && op == bsl_pkg::OP_LOAD_PTR_INC |-> read_s(1'b0)
        ##0 mem_addr_out == $past(instr_in.addr) ##1 result_out.ptr_we
        && result_out.ptr_data == $past(instr_in.addr, 2) + 16'h0001) else $error("post increment load");
    pre_dec_a: assert property (take && op == bsl_pkg::OP_LOAD_PTR_DEC |-> read_s(1'b0)
        ##0 mem_addr_out == $past(instr_in.addr) - 16'h0001) else $error("pre decrement address");
endmodule

bind branch_skip_load_exec branch_skip_load_exec_checker chk (.clk_in, .rst_n_in, .issue_in, .instr_in,
    .busy_out, .status_flags_reg_in, .mem_rd_out, .mem_io_out, .mem_addr_out, .done_out, .result_out,
    .flags_we_out, .cycles_out);

// file: data_space_model.sv
// data space and i/o read port seen by the execution unit
// answers a read while its strobe stands, with a value made from the address
`timescale 1ns/100ps
module data_space_model (
    // read port
    input  wire logic        rd_in,
    input  wire logic        io_in,
    input  wire logic [15:0] addr_in,
    output logic [7:0]       data_out
);
    // outside a read the bus shows the inverse, so a stray sample never matches
    always_comb begin
        data_out = addr_in[7:0] ^ addr_in[15:8] ^ {io_in, 7'h35};
        if (!rd_in) begin
            data_out = ~data_out;
        end
    end
endmodule

// file: tb.sv
// self-checking bench for the branch, skip and load execution unit
// drives decoded instructions and flags; the data space model answers reads
`timescale 1ns/100ps
module tb;
    logic             clk_in = 1'b0;
    logic             rst_n_in = 1'b0;
    logic             issue_in = 1'b0;
    bsl_pkg::instr_t  instr_in = '0;
    logic [7:0]       status_flags_reg_in = 8'h00;
    logic             busy_out, mem_rd_out, mem_io_out, done_out, flags_we_out;
    logic [15:0]      mem_addr_out;
    logic [7:0]       mem_data_in, flags_out;
    logic [2:0]       cycles_out;
    bsl_pkg::result_t result_out;
    int               n_fail = 0;
    int               num_checks = 0;
    logic [15:0]      pc_exp = bsl_pkg::PC_RESET;

    branch_skip_load_exec uut (.clk_in, .rst_n_in, .issue_in, .instr_in, .busy_out, .status_flags_reg_in,
        .mem_rd_out, .mem_io_out, .mem_addr_out, .mem_data_in, .done_out, .result_out, .flags_we_out,
        .flags_out, .cycles_out);
    data_space_model mem (.rd_in(mem_rd_out), .io_in(mem_io_out), .addr_in(mem_addr_out),
        .data_out(mem_data_in));

    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] mem_val(input logic [15:0] a, input logic io);
        return a[7:0] ^ a[15:8] ^ {io, 7'h35};
    endfunction

    function automatic logic [7:0] cmp_flags(input logic [7:0] d, r, f, input logic use_c);
        logic [8:0] s;
        logic [7:0] o;
        s = {1'b0, d} - {1'b0, r} - {8'h00, use_c & f[bsl_pkg::FLAG_C]};
        o = f;
        o[bsl_pkg::FLAG_C] = s[8];
        o[bsl_pkg::FLAG_Z] = (s[7:0] == 8'h00) & (!use_c | f[bsl_pkg::FLAG_Z]);
        o[bsl_pkg::FLAG_N] = s[7];
        o[bsl_pkg::FLAG_V] = (d[7] & ~r[7] & ~s[7]) | (~d[7] & r[7] & s[7]);
        o[bsl_pkg::FLAG_S] = s[7] ^ o[bsl_pkg::FLAG_V];
        o[bsl_pkg::FLAG_H] = (~d[3] & r[3]) | (r[3] & s[3]) | (s[3] & ~d[3]);
        return o;
    endfunction

    task automatic run_one(input bsl_pkg::instr_t i);
        logic [7:0]  f;
        logic [7:0]  iob;
        logic        sk;
        logic [2:0]  cyc;
        logic [15:0] pc_nxt;
        logic [15:0] ea;
        int          n;
        f = 8'($urandom());
        iob = mem_val(i.addr, 1'b1);
        @(posedge clk_in);
        issue_in <= 1'b1;
        instr_in <= i;
        status_flags_reg_in <= f;
        @(posedge clk_in);
        issue_in <= 1'b0;
        #1;
        n = 0;
        while (done_out !== 1'b1 && n < 8) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (done_out !== 1'b1) begin
            n_fail++;
            give_verdict();
        end
        sk = 1'b0;
        case (i.op)
            bsl_pkg::OP_COMPARE_SKIP_EQUAL: sk = (i.rd_val == i.rr_val);
            bsl_pkg::OP_SKIP_REG_BIT_CLEAR: sk = !i.rd_val[i.bit_sel];
            bsl_pkg::OP_SKIP_REG_BIT_SET: sk = i.rd_val[i.bit_sel];
            bsl_pkg::OP_SKIP_IO_BIT_CLEAR: sk = !iob[i.bit_sel];
            bsl_pkg::OP_SKIP_IO_BIT_SET: sk = iob[i.bit_sel];
            bsl_pkg::OP_BRANCH_FLAG_SET: sk = f[i.bit_sel];
            bsl_pkg::OP_BRANCH_FLAG_CLEAR: sk = !f[i.bit_sel];
            bsl_pkg::OP_BRANCH_SIGNED_GE: sk = !(f[bsl_pkg::FLAG_N] ^ f[bsl_pkg::FLAG_V]);
            bsl_pkg::OP_BRANCH_SIGNED_LT: sk = f[bsl_pkg::FLAG_N] ^ f[bsl_pkg::FLAG_V];
            default: sk = 1'b0;
        endcase
        cyc = 3'h1;
        pc_nxt = pc_exp + 16'h0001;
        if (i.op inside {[bsl_pkg::OP_COMPARE_SKIP_EQUAL:bsl_pkg::OP_SKIP_IO_BIT_SET]}) begin
            cyc = 3'h1 + 3'(sk) + 3'(sk & i.next_long) + 3'(i.op >= bsl_pkg::OP_SKIP_IO_BIT_CLEAR);
            pc_nxt = pc_exp + 16'h0001 + 16'(sk) + 16'(sk & i.next_long);
        end else if (i.op inside {[bsl_pkg::OP_BRANCH_FLAG_SET:bsl_pkg::OP_BRANCH_SIGNED_LT]}) begin
            cyc = 3'h1 + 3'(sk);
            pc_nxt = sk ? pc_exp + {{9{i.offset[6]}}, i.offset} + 16'h0001 : pc_nxt;
        end else if (i.op == bsl_pkg::OP_LOAD_DIRECT) begin
            cyc = 3'h2;
            pc_nxt = pc_exp + 16'h0002;
        end else if (i.op == bsl_pkg::OP_LOAD_PTR_DEC) begin
            cyc = 3'h2;
        end
        compare(16'(cycles_out), 16'(cyc));
        compare(16'(flags_we_out), 16'(i.op <= bsl_pkg::OP_COMPARE_IMMEDIATE));
        if (i.op <= bsl_pkg::OP_COMPARE_IMMEDIATE) begin
            compare(16'(flags_out & 8'h3F),
                16'(cmp_flags(i.rd_val, i.rr_val, f, i.op == bsl_pkg::OP_COMPARE_REGS_CARRY) & 8'h3F));
        end
        if (i.op >= bsl_pkg::OP_LOAD_DIRECT) begin
            ea = (i.op == bsl_pkg::OP_LOAD_PTR_DEC) ? i.addr - 16'h0001 : i.addr;
            compare(16'(result_out.rd_data), 16'(mem_val(ea, 1'b0)));
        end
        if (i.op >= bsl_pkg::OP_LOAD_PTR_INC) begin
            compare(result_out.ptr_data, (i.op == bsl_pkg::OP_LOAD_PTR_INC) ? i.addr + 16'h0001 : ea);
        end
        compare(16'(busy_out), 16'h0000);
        @(posedge clk_in);
        #1;
        compare(result_out.pc, pc_nxt);
        pc_exp = pc_nxt;
    endtask

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    initial begin
        bsl_pkg::instr_t t;
        void'($urandom(32'h6d1454a6));
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int k = 0; k < 480; k++) begin
            t = 48'({$urandom(), $urandom()});
            t.op = bsl_pkg::op_t'(5'(1 + k % 16));
            // equal operands give zero compares and taken equal skips
            if (k % 5 == 0) begin
                t.rr_val = t.rd_val;
            end
            // most negative offset and pointer wrap at the address ends
            if (k < 32) begin
                t.offset = 7'h40;
                t.addr = (k < 16) ? 16'h0000 : 16'hFFFF;
            end
            run_one(t);
        end
        give_verdict();
    end
endmodule
